//--- core/sac_consts.svh
// Offsets, field positions, reset values and timing counts of the servo alarm block.
// Assumes inclusion by bare name, from files with or without sac_pkg imported.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave
`define SAC_OFS_CONFIG 8'h00
`define SAC_OFS_CTRL 8'h04
`define SAC_OFS_STATUS 8'h08
`define SAC_OFS_MASK 8'h0C
`define SAC_OFS_ALARM 8'h10
`define SAC_OFS_PMIN 8'h14
`define SAC_OFS_PMAX 8'h18

// System configuration word fields
`define SAC_CFG_ABS_SEL_BIT 14
`define SAC_CFG_SEN_MODE_BIT 1

// Control register fields
`define SAC_CTRL_ALM_RST_BIT 0
`define SAC_CTRL_POS_MODE_BIT 1

// Status and mask bit positions
`define SAC_ST_ABS_BIT 0
`define SAC_ST_CORRUPT_BIT 1
`define SAC_ST_RANGE_BIT 2
`define SAC_ST_OVC_BIT 3
`define SAC_ST_SEN_SHORT_BIT 4
`define SAC_ST_WIDTH 5

// Reset values
`define SAC_RST_CONFIG 16'h0000
`define SAC_RST_MASK 5'h00
`define SAC_RST_PMIN 16'h0000
`define SAC_RST_PMAX 16'hFFFF

// Display codes of each alarm and of the no-alarm indication
`define SAC_DISP_ABS 8'h00
`define SAC_DISP_CORRUPT 8'h02
`define SAC_DISP_RANGE 8'h04
`define SAC_DISP_OVC 8'h10
`define SAC_DISP_NONE 8'h99

// Timing: least high time of the sensor-on request before a drop
`define SAC_CLK_PERIOD_NS 8
`define SAC_SEN_HOLD_MS 1300

`endif

//--- core/sac_pkg.sv
// Types shared by the servo alarm block and its alarm code encoder.
// Assumes no other package.
package sac_pkg;

  typedef enum logic [1:0] {SEN_LOW, SEN_HIGH} sac_sen_st_t;

  typedef struct packed {
    logic [15:0] config_word;
    logic pos_mode;
    logic [4:0] status;
    logic [4:0] mask;
    logic [15:0] pmin;
    logic [15:0] pmax;
    logic act_abs;
    logic act_corrupt;
    logic act_range;
    logic act_ovc;
    logic pwr_up;
    sac_sen_st_t sen_st;
    logic [27:0] sen_cnt;
    logic sen_armed;
    logic acq_restart;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
  } sac_state_t;

  typedef struct packed {
    logic code_a;
    logic code_b;
    logic code_c;
    logic alarm_on;
    logic [7:0] disp;
  } sac_enc_state_t;

endpackage

//--- core/sac_code_encoder.sv
// Alarm code encoder: turns the active alarm flags into output transistor states.
// Assumes flags come from flip-flops in the same clock domain.
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_code_encoder import sac_pkg::*; (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic act_abs_in,
  input wire logic act_corrupt_in,
  input wire logic act_range_in,
  input wire logic act_ovc_in,
  output logic code_a_out,
  output logic code_b_out,
  output logic code_c_out,
  output logic alarm_on_out,
  output logic [7:0] disp_out
);

  sac_enc_state_t s;
  sac_enc_state_t next_s;

  // Highest priority alarm picks the code; a high bit means the transistor conducts
  always_comb begin
    next_s = s;
    next_s.code_a = 1'b0;
    next_s.code_b = 1'b0;
    next_s.code_c = 1'b0;
    next_s.alarm_on = 1'b0;
    if (act_abs_in) begin
      next_s.disp = `SAC_DISP_ABS; // All outputs off
    end else if (act_corrupt_in) begin
      next_s.disp = `SAC_DISP_CORRUPT; // All outputs off
    end else if (act_range_in) begin
      next_s.disp = `SAC_DISP_RANGE; // All outputs off
    end else if (act_ovc_in) begin
      next_s.disp = `SAC_DISP_OVC;
      next_s.code_a = 1'b1; // Only first code transistor on
    end else begin
      next_s.disp = `SAC_DISP_NONE; // No-alarm indication
      next_s.alarm_on = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '{code_a: 1'b0, code_b: 1'b0, code_c: 1'b0, alarm_on: 1'b0, disp: `SAC_DISP_NONE};
    end else begin
      s <= next_s;
    end
  end

  assign code_a_out = s.code_a;
  assign code_b_out = s.code_b;
  assign code_c_out = s.code_c;
  assign alarm_on_out = s.alarm_on;
  assign disp_out = s.disp;

endmodule

//--- core/sac_alarm_unit.sv
// Servo alarm unit: alarm latches, clearing policy, sensor-on request tracking,
// interrupt status and an AHB-Lite register slave.
// Assumes all inputs synchronous to clk_in; nrst_in low only at power-up.
`timescale 1ns/10ps
`include "sac_consts.svh"

// Contract
// - Parameter corruption alarm turns all three code outputs and alarm output off.
// - Parameter range alarm turns all three code outputs and alarm output off.
// - Each code bit is a transistor state: one conducts, zero is off.
// - Absolute position data alarm clears only by power cycle.
// - Ordinary alarm reset leaves a latched absolute data alarm active.
// - The no-alarm display code raises no alarm condition.
// - Overcurrent alarm cannot be cleared while power module overheats.
// - Absolute select bit set with incremental encoder raises absolute data alarm.
// - Speed mode, config bit 1 clear: sensor-on re-toggle restarts acquisition if the request was held high over SEN_HOLD_CYC cycles before the drop.
// - Otherwise acquisition restarts only at power-up.
// - Corrupted parameter store found at power-up raises corruption alarm.
// - Out-of-range parameter value raises range alarm.
module sac_alarm_unit import sac_pkg::*; #(
  parameter int SEN_HOLD_CYC =
    (`SAC_SEN_HOLD_MS * 1000000 + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Alarm causes
  input wire logic param_store_ok_in,
  input wire logic param_valid_in,
  input wire logic [15:0] param_value_in,
  input wire logic abs_data_error_in,
  input wire logic encoder_incremental_in,
  input wire logic overcurrent_in,
  input wire logic overtemp_in,
  input wire logic alarm_reset_in,
  input wire logic encoder_sensor_on_request_in,
  // Outputs toward the host controller
  output logic alarm_code_bit_a_out,
  output logic alarm_code_bit_b_out,
  output logic alarm_code_bit_c_out,
  output logic alarm_out,
  output logic abs_acq_restart_out,
  output logic irq_out
);

  sac_state_t s;
  sac_state_t next_s;
  logic addr_ok;
  logic mapped;
  logic alm_rst;
  logic range_viol;
  logic abs_set;
  logic corrupt_set;
  logic [4:0] ev;
  logic [31:0] rd_mux;
  logic [7:0] disp_code;
  logic code_a;
  logic code_b;
  logic code_c;
  logic alarm_on;

  // Address phase decode
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;
  assign mapped = (haddr_in[31:8] == 24'h000000) && (haddr_in[1:0] == 2'b00) &&
                  (haddr_in[7:0] <= `SAC_OFS_PMAX);

  // Read data for the register addressed now
  always_comb begin
    rd_mux = 32'h00000000;
    if (mapped) begin
      case (haddr_in[7:0])
        `SAC_OFS_CONFIG: rd_mux = {16'h0000, s.config_word};
        `SAC_OFS_CTRL: rd_mux = {30'h00000000, s.pos_mode, 1'b0};
        `SAC_OFS_STATUS: rd_mux = {27'h0000000, s.status};
        `SAC_OFS_MASK: rd_mux = {27'h0000000, s.mask};
        `SAC_OFS_ALARM: rd_mux = {11'h000, abs_acq_restart_out, alarm_on, code_c, code_b,
                                  code_a, disp_code, 4'h0, s.act_ovc, s.act_range,
                                  s.act_corrupt, s.act_abs};
        `SAC_OFS_PMIN: rd_mux = {16'h0000, s.pmin};
        `SAC_OFS_PMAX: rd_mux = {16'h0000, s.pmax};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Alarm causes seen this cycle
  assign range_viol = param_valid_in &
                      ((param_value_in < s.pmin) | (param_value_in > s.pmax));
  assign abs_set = abs_data_error_in |
                   (s.config_word[`SAC_CFG_ABS_SEL_BIT] & encoder_incremental_in);
  assign corrupt_set = s.pwr_up & ~param_store_ok_in;

  // Software alarm reset comes from the pin or a control register write
  assign alm_rst = alarm_reset_in |
                   (s.wr_pend && (s.wr_addr == `SAC_OFS_CTRL) &&
                    hwdata_in[`SAC_CTRL_ALM_RST_BIT]);

  // Next state of the whole unit
  always_comb begin
    next_s = s;
    ev = 5'h00;
    next_s.acq_restart = 1'b0;

    // Data phase of a write
    if (s.wr_pend) begin
      case (s.wr_addr)
        `SAC_OFS_CONFIG: next_s.config_word = hwdata_in[15:0];
        `SAC_OFS_CTRL: next_s.pos_mode = hwdata_in[`SAC_CTRL_POS_MODE_BIT];
        `SAC_OFS_STATUS: next_s.status = s.status & ~hwdata_in[4:0];
        `SAC_OFS_MASK: next_s.mask = hwdata_in[4:0];
        `SAC_OFS_PMIN: next_s.pmin = hwdata_in[15:0];
        `SAC_OFS_PMAX: next_s.pmax = hwdata_in[15:0];
        default: next_s.wr_pend = 1'b0;
      endcase
    end

    // Address phase capture; read data is ready for the data phase
    next_s.wr_pend = addr_ok & hwrite_in & mapped;
    next_s.wr_addr = haddr_in[7:0];
    if (addr_ok && !hwrite_in) begin
      next_s.hrdata = rd_mux;
    end

    // Power-up: one parameter store check and one acquisition start
    next_s.pwr_up = 1'b0;
    if (s.pwr_up) begin
      next_s.acq_restart = 1'b1;
    end

    // Absolute data alarm: no clear path but reset
    if (abs_set) begin
      next_s.act_abs = 1'b1; // Alarm reset ignored here
      ev[`SAC_ST_ABS_BIT] = ~s.act_abs;
    end

    // Parameter corruption alarm stays until the next power-up
    if (corrupt_set) begin
      next_s.act_corrupt = 1'b1;
      ev[`SAC_ST_CORRUPT_BIT] = 1'b1;
    end

    // Range alarm: reset clears, a new violation wins
    if (alm_rst) begin
      next_s.act_range = 1'b0;
    end
    if (range_viol) begin
      next_s.act_range = 1'b1;
      ev[`SAC_ST_RANGE_BIT] = ~s.act_range;
    end

    // Overcurrent: reset refused while the power module is hot
    if (alm_rst && !overtemp_in) begin
      next_s.act_ovc = 1'b0;
    end
    if (overcurrent_in) begin
      next_s.act_ovc = 1'b1;
      ev[`SAC_ST_OVC_BIT] = ~s.act_ovc;
    end

    // Sensor-on request tracking
    case (s.sen_st)
      SEN_LOW: begin
        if (encoder_sensor_on_request_in) begin
          next_s.sen_st = SEN_HIGH;
          next_s.sen_cnt = 28'h0000000;
          next_s.sen_armed = 1'b0;
          if (s.sen_armed && !s.pos_mode && !s.config_word[`SAC_CFG_SEN_MODE_BIT]) begin
            next_s.acq_restart = 1'b1;
          end
        end
      end
      SEN_HIGH: begin
        if (!encoder_sensor_on_request_in) begin
          next_s.sen_st = SEN_LOW;
          if (s.sen_cnt > 28'(SEN_HOLD_CYC)) begin
            next_s.sen_armed = 1'b1; // Held long enough
          end else begin
            ev[`SAC_ST_SEN_SHORT_BIT] = 1'b1; // Dropped too early
          end
        end else if (s.sen_cnt != 28'hFFFFFFF) begin
          next_s.sen_cnt = s.sen_cnt + 28'h0000001;
        end
      end
      default: next_s.sen_st = SEN_LOW;
    endcase

    // Events set sticky status after any clear, so a set wins
    next_s.status = next_s.status | ev;
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '{config_word: `SAC_RST_CONFIG, pos_mode: 1'b0, status: 5'h00,
             mask: `SAC_RST_MASK, pmin: `SAC_RST_PMIN, pmax: `SAC_RST_PMAX,
             act_abs: 1'b0, act_corrupt: 1'b0, act_range: 1'b0, act_ovc: 1'b0,
             pwr_up: 1'b1, sen_st: SEN_LOW, sen_cnt: 28'h0000000, sen_armed: 1'b0,
             acq_restart: 1'b0, wr_pend: 1'b0, wr_addr: 8'h00, hrdata: 32'h00000000};
    end else begin
      s <= next_s;
    end
  end

  // Alarm code encoder
  sac_code_encoder u_enc (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .act_abs_in(s.act_abs),
    .act_corrupt_in(s.act_corrupt),
    .act_range_in(s.act_range),
    .act_ovc_in(s.act_ovc),
    .code_a_out(code_a),
    .code_b_out(code_b),
    .code_c_out(code_c),
    .alarm_on_out(alarm_on),
    .disp_out(disp_code)
  );

  // Outputs; no-alarm never raises the interrupt
  assign alarm_code_bit_a_out = code_a;
  assign alarm_code_bit_b_out = code_b;
  assign alarm_code_bit_c_out = code_c;
  assign alarm_out = alarm_on;
  assign abs_acq_restart_out = s.acq_restart;
  assign irq_out = |(s.status & s.mask);
  assign hrdata_out = s.hrdata;
  assign hreadyout_out = 1'b1; // Zero wait states
  assign hresp_out = 1'b0; // Always OKAY

endmodule

//--- dv/sac_alarm_checker.sv
// Port checker of the alarm unit: output levels tied to their causes.
// Assumes one clock domain; bound to every alarm unit instance.
`timescale 1ns/10ps
module sac_alarm_checker (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic param_store_ok_in,
  input wire logic abs_data_error_in,
  input wire logic overcurrent_in,
  input wire logic overtemp_in,
  input wire logic alarm_reset_in,
  input wire logic encoder_sensor_on_request_in,
  input wire logic alarm_code_bit_a_out,
  input wire logic alarm_code_bit_b_out,
  input wire logic alarm_code_bit_c_out,
  input wire logic alarm_out,
  input wire logic abs_acq_restart_out
);
  logic [1:0] up_cnt;
  // Cycles since reset release, saturating
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Output relations
  bc_off_a: assert property (!alarm_code_bit_b_out && !alarm_code_bit_c_out)
    else $error("Code b or c on");
  code_excl_a: assert property (alarm_out |-> !alarm_code_bit_a_out)
    else $error("Code a with no alarm");
  ovc_out_a: assert property (overcurrent_in |=> ##1 !alarm_out)
    else $error("Overcurrent left alarm output on");
  abs_hold_a: assert property (abs_data_error_in |=> ##1 (!alarm_out && !alarm_code_bit_a_out)[*8])
    else $error("Absolute alarm not held");
  ovc_temp_a: assert property ((alarm_code_bit_a_out && overtemp_in && alarm_reset_in) |=> ##1 !alarm_out)
    else $error("Overcurrent cleared while hot");
  restart_src_a: assert property (abs_acq_restart_out |-> (up_cnt == 2'h1) || ($past(encoder_sensor_on_request_in) && !$past(encoder_sensor_on_request_in, 2)))
    else $error("Restart pulse without cause");
  corrupt_up_a: assert property ((up_cnt == 2'h1 && !$past(param_store_ok_in)) |=> (!alarm_out)[*8])
    else $error("Corrupt store not flagged");
  ahb_resp_a: assert property (hreadyout_out && !hresp_out)
    else $error("Bus not ready or error");
endmodule

bind sac_alarm_unit sac_alarm_checker sac_alarm_checker_inst (.clk_in, .nrst_in, .hreadyout_out,
  .hresp_out, .param_store_ok_in, .abs_data_error_in, .overcurrent_in, .overtemp_in,
  .alarm_reset_in, .encoder_sensor_on_request_in, .alarm_code_bit_a_out, .alarm_code_bit_b_out,
  .alarm_code_bit_c_out, .alarm_out, .abs_acq_restart_out);

//--- dv/sac_host_model.sv
// Host controller model: drives the sensor-on request, counts restart pulses.
// Assumes the clock of the alarm unit; called right after a rising edge.
`timescale 1ns/10ps
module sac_host_model #(parameter int HOLD_CYC = 20) (
  input wire logic clk_in,
  input wire logic restart_in,
  output logic sen_out = 1'b0,
  output logic [7:0] pulse_cnt_out = 8'h00
);
  // Counts acquisition restart pulses
  always @(posedge clk_in) begin
    if (restart_in === 1'b1) begin
      pulse_cnt_out <= pulse_cnt_out + 8'h01;
    end
  end
  // Drop and raise the request; a careless host drops it early
  task automatic retoggle(input bit early);
    sen_out <= 1'b1;
    repeat (early ? HOLD_CYC / 2 : HOLD_CYC + 4) @(posedge clk_in);
    sen_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    sen_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

//--- dv/sac_alarm_unit_tb_top.sv
// Testbench of the alarm unit: bus tasks, alarm causes, host model.
// Assumes the checker is bound to the unit by its own file.
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_alarm_unit_tb_top;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic hsel = 1'b0, hwr = 1'b0, ok = 1'b1, pvld = 1'b0, aerr = 1'b0;
  logic incr = 1'b0, ovc = 1'b0, hot = 1'b0, arst = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [2:0] hsz = 3'h2;
  logic [31:0] haddr = 32'h0, hwd = 32'h0, rd;
  logic [15:0] pval = 16'h0000;
  logic [7:0] n;
  wire logic [31:0] hrd;
  wire logic [7:0] pcnt;
  wire logic hrdy, hresp, ca, cb, cc, alm, rstp, irq, encoder_sensor_on_request;
  int errors = 0, check_count = 0, cyc = 0;

  always #4 clk_in = ~clk_in;

  sac_alarm_unit #(.SEN_HOLD_CYC(20)) sac_alarm_unit_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(hsz),
    .hready_in(hrdy), .hwdata_in(hwd), .hrdata_out(hrd), .hreadyout_out(hrdy),
    .hresp_out(hresp), .param_store_ok_in(ok), .param_valid_in(pvld), .param_value_in(pval),
    .abs_data_error_in(aerr), .encoder_incremental_in(incr), .overcurrent_in(ovc),
    .overtemp_in(hot), .alarm_reset_in(arst), .encoder_sensor_on_request_in(encoder_sensor_on_request),
    .alarm_code_bit_a_out(ca), .alarm_code_bit_b_out(cb), .alarm_code_bit_c_out(cc),
    .alarm_out(alm), .abs_acq_restart_out(rstp), .irq_out(irq));
  sac_host_model #(.HOLD_CYC(20)) sac_host_model_inst (.clk_in(clk_in), .restart_in(rstp),
    .sen_out(encoder_sensor_on_request), .pulse_cnt_out(pcnt));

  task summarize;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; htr <= 2'h2; haddr <= a; hwr <= w;
    @(posedge clk_in); while (hrdy !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0; htr <= 2'h0; hwd <= d;
    @(posedge clk_in); while (hrdy !== 1'b1) @(posedge clk_in);
    rd = hrd;
  endtask
  task settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task outs(input logic [3:0] e);
    settle;
    chk({ca, cb, cc, alm}, e);
  endtask
  task tick;
    @(posedge clk_in);
    {pvld, aerr, ovc, arst} <= 4'h0;
  endtask
  task power_up(input logic good);
    nrst_in <= 1'b0; ok <= good;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
  endtask

  task t_range;
    ahb(1, `SAC_OFS_PMAX, 32'h0100); pval <= 16'h0200; pvld <= 1'b1; tick;
    outs(4'b0000);
    ahb(0, `SAC_OFS_ALARM, 0); chk(rd[15:8], `SAC_DISP_RANGE);
    ahb(1, `SAC_OFS_CTRL, 32'h1); outs(4'b0001);
    pval <= 16'h0100; pvld <= 1'b1; tick; outs(4'b0001);
    ahb(1, `SAC_OFS_PMAX, 32'hFFFF);
  endtask
  task t_ovc;
    ahb(1, `SAC_OFS_MASK, 32'h8); ovc <= 1'b1; tick; outs(4'b1000);
    chk(irq, 1'b1);
    hot <= 1'b1; arst <= 1'b1; tick; outs(4'b1000);
    hot <= 1'b0; arst <= 1'b1; tick; outs(4'b0001);
    ahb(1, `SAC_OFS_STATUS, 32'h8); settle; chk(irq, 1'b0);
    ahb(0, 32'h40, 0); chk(rd, 32'h0);
  endtask
  task t_abs;
    ahb(1, `SAC_OFS_CONFIG, 32'h4000); incr <= 1'b1; outs(4'b0000);
    ahb(1, `SAC_OFS_CONFIG, 0); incr <= 1'b0; ahb(1, `SAC_OFS_CTRL, 32'h1);
    outs(4'b0000);
    aerr <= 1'b1; tick; arst <= 1'b1; tick; outs(4'b0000);
    n = pcnt; power_up(1'b1); outs(4'b0001);
    chk(pcnt, n + 8'h01);
  endtask
  task t_sen;
    n = pcnt; sac_host_model_inst.retoggle(0); settle; chk(pcnt, n + 8'h01);
    n = pcnt; sac_host_model_inst.retoggle(1); settle; chk(pcnt, n);
    ahb(0, `SAC_OFS_STATUS, 0); chk(rd[4], 1'b1);
    ahb(1, `SAC_OFS_CTRL, 32'h2);
    n = pcnt; sac_host_model_inst.retoggle(0); settle; chk(pcnt, n);
    ahb(1, `SAC_OFS_CTRL, 0); ahb(1, `SAC_OFS_CONFIG, 32'h2);
    n = pcnt; sac_host_model_inst.retoggle(0); settle; chk(pcnt, n);
  endtask
  task t_corrupt;
    power_up(1'b0); outs(4'b0000);
    arst <= 1'b1; tick; outs(4'b0000);
    power_up(1'b1); outs(4'b0001);
    ahb(0, `SAC_OFS_ALARM, 0); chk(rd[15:8], `SAC_DISP_NONE);
  endtask

  // Ceiling on run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      summarize;
    end
  end
  // Main sequence
  initial begin
    power_up(1'b1);
    t_range;
    t_ovc;
    t_abs;
    t_sen;
    t_corrupt;
    summarize;
  end
endmodule
